// File: memory_clock_divide_pkg.sv
// Purpose: constants for the memory clock divider block
// Assumes: classic Wishbone slave with 32-bit data, byte-wide register in the low lane
// Notes: option locations and key are small parameter arrays supplied at elaboration
package memory_clock_divide_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [15:0] MEMORY_CLOCK_DIVIDE_ADDR = 16'h1820;
	localparam logic [15:0] OPTION_BASE_ADDR = 16'h1821;
	localparam logic [15:0] STATUS_ADDR = 16'h1830;
	localparam logic [15:0] KEY_BASE_ADDR = 16'h1840;
	localparam logic [7:0] MEMORY_CLOCK_DIVIDE_RESET = 8'h00;
	localparam int LOADED_BIT = 7;
	localparam int PRESCALE_BIT = 6;
	localparam int DIVISOR_LSB = 0;
	localparam int DIVISOR_WIDTH = 6;
	localparam int WRITE_ONCE_MSB = 6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PRESCALE_RATIO = 8;
	localparam int CLK_SYS_MHZ = 100;
	localparam int OPTION_COUNT = 3;
	localparam int KEY_BYTES = 8;
	// status register bits
	localparam int STAT_ENABLE_BIT = 0;
	localparam int STAT_TICK_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	// unmapped reads return this
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : memory_clock_divide_pkg

// File: memory_clock_divide_tick_gen.sv
// Purpose: divides the bus clock into one-cycle timing pulses
// Assumes: settings are stable once loaded
// Notes: pulse period is (divisor+1) or 8*(divisor+1) bus cycles
`timescale 1ns/10ps
module memory_clock_divide_tick_gen
	import memory_clock_divide_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// settings
	input wire logic enable,
	input wire logic prescaleByEight,
	input wire logic [DIVISOR_WIDTH-1:0] divisor,
	// output
	output logic memTick
);
	logic [2:0] preCnt_r;
	logic [DIVISOR_WIDTH-1:0] divCnt_r;
	logic preTick;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// select full rate or one pulse in eight
	assign preTick = prescaleByEight ? (preCnt_r == 3'(PRESCALE_RATIO - 1)) : 1'b1;

	always_ff @(posedge clk_sys) begin
		if (srst || !enable) begin
			preCnt_r <= 3'h0;
		end else begin
			preCnt_r <= preCnt_r + 3'h1; // wraps at eight
		end
	end

	// ----------------------------------------------------------------
	// divisor plus one
	// ----------------------------------------------------------------
	// a pulse every divisor+1 selected input ticks
	always_ff @(posedge clk_sys) begin
		if (srst || !enable) begin
			divCnt_r <= '0;
			memTick <= 1'b0;
		end else begin
			memTick <= 1'b0;
			if (preTick) begin
				if (divCnt_r == divisor) begin
					divCnt_r <= '0;
					memTick <= 1'b1;
				end else begin
					divCnt_r <= divCnt_r + 1'b1;
				end
			end
		end
	end
endmodule : memory_clock_divide_tick_gen

// File: memory_clock_divide_ctrl.sv
// Purpose: nonvolatile memory clock divider with write-once register and op gate
// Assumes: classic Wishbone slave; software programs a rate of 150 kHz to 200 kHz
// Notes: erase/program timer counts whole timing pulses of the divided clock
`timescale 1ns/10ps
module memory_clock_divide_ctrl
	import memory_clock_divide_pkg::*;
#(
	parameter int OP_PULSE_WIDTH = 16,
	parameter logic [OPTION_COUNT*8-1:0] OPTION_NV = 24'h0,
	parameter logic [KEY_BYTES*8-1:0] KEY_NV = 64'h0 // arbitrary value
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// erase / program request from the sequencer
	input wire logic opStart,
	input wire logic [OP_PULSE_WIDTH-1:0] opPulses,
	output logic opBusy,
	output logic opDone,
	output logic opRefused,
	// memory timing
	output logic memTick,
	output logic opEnable,
	// option copies and key
	output logic [OPTION_COUNT*8-1:0] optionWork,
	output logic [KEY_BYTES*8-1:0] compareKey
);
	initial begin
		if (OP_PULSE_WIDTH < 1 || OP_PULSE_WIDTH > 24) begin
			$error("OP_PULSE_WIDTH out of range");
		end
	end

	logic [WRITE_ONCE_MSB:0] divSetting_r;
	logic divisorLoadedFlag_r;
	logic [OPTION_COUNT*8-1:0] optionWork_r;
	logic [OP_PULSE_WIDTH-1:0] opLeft_r;
	logic opBusy_r;
	logic opDone_r;
	logic opRefused_r;
	logic access;
	logic wrByte0;
	logic [31:0] rdData;
	logic [7:0] dividerRead;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// single-cycle answer: ack one edge after the request, low the next
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wrByte0 = access && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			if (access && !wb_we_i) begin
				wb_dat_o <= rdData;
			end
		end
	end

	// ----------------------------------------------------------------
	// divider register
	// ----------------------------------------------------------------
	// seven low bits taken on the first write only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			divSetting_r <= MEMORY_CLOCK_DIVIDE_RESET[WRITE_ONCE_MSB:0];
		end else if (wrByte0 && wb_adr_i == MEMORY_CLOCK_DIVIDE_ADDR
			&& !divisorLoadedFlag_r) begin
			divSetting_r <= wb_dat_i[WRITE_ONCE_MSB:0];
		end
	end

	// loaded flag: set by the first write whatever its data, bit 7 ignored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			divisorLoadedFlag_r <= MEMORY_CLOCK_DIVIDE_RESET[LOADED_BIT];
		end else if (wrByte0 && wb_adr_i == MEMORY_CLOCK_DIVIDE_ADDR) begin
			divisorLoadedFlag_r <= 1'b1;
		end
	end

	assign dividerRead = {divisorLoadedFlag_r, divSetting_r};
	assign opEnable = divisorLoadedFlag_r;

	// ----------------------------------------------------------------
	// option copies taken during reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			optionWork_r <= OPTION_NV;
		end
	end
	assign optionWork = optionWork_r;
	assign compareKey = KEY_NV;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdData = UNMAPPED_DATA;
		if (wb_adr_i == MEMORY_CLOCK_DIVIDE_ADDR) begin
			rdData = {24'h000000, dividerRead};
		end else if (wb_adr_i == STATUS_ADDR) begin
			rdData[STAT_ENABLE_BIT] = divisorLoadedFlag_r;
			rdData[STAT_TICK_BIT] = memTick;
			rdData[STAT_BUSY_BIT] = opBusy_r;
		end
		for (int i = 0; i < OPTION_COUNT; i++) begin
			if (wb_adr_i == OPTION_BASE_ADDR + 16'(i)) begin
				rdData = {24'h000000, optionWork_r[i*8 +: 8]};
			end
		end
	end

	// ----------------------------------------------------------------
	// timing pulse generator
	// ----------------------------------------------------------------
	memory_clock_divide_tick_gen u_tick (
		.clk_sys(clk_sys),
		.srst(srst),
		.enable(divisorLoadedFlag_r),
		.prescaleByEight(divSetting_r[PRESCALE_BIT]),
		.divisor(divSetting_r[DIVISOR_LSB +: DIVISOR_WIDTH]),
		.memTick(memTick)
	);

	// ----------------------------------------------------------------
	// erase / program timer
	// ----------------------------------------------------------------
	// counts whole pulses; starts refused until the divider is loaded
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			opBusy_r <= 1'b0;
			opDone_r <= 1'b0;
			opRefused_r <= 1'b0;
			opLeft_r <= '0;
		end else begin
			opDone_r <= 1'b0;
			opRefused_r <= 1'b0;
			if (!opBusy_r && opStart) begin
				if (!divisorLoadedFlag_r || opPulses == '0) begin
					opRefused_r <= 1'b1;
				end else begin
					opBusy_r <= 1'b1;
					opLeft_r <= opPulses;
				end
			end else if (opBusy_r && memTick) begin
				if (opLeft_r == OP_PULSE_WIDTH'(1)) begin
					opBusy_r <= 1'b0;
					opDone_r <= 1'b1;
				end
				opLeft_r <= opLeft_r - 1'b1;
			end
		end
	end
	assign opBusy = opBusy_r;
	assign opDone = opDone_r;
	assign opRefused = opRefused_r;
endmodule : memory_clock_divide_ctrl

// File: memory_clock_divide_chk.sv
// Purpose: port checker for the memory clock divider
// Assumes: bound to memory_clock_divide_ctrl, one clock domain
// Notes: ties flag, gate and pulses to their bus causes
`timescale 1ns/10ps
module memory_clock_divide_chk
	import memory_clock_divide_pkg::*;
#(
	parameter int OP_PULSE_WIDTH = 16
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// operation port
	input wire logic opStart,
	input wire logic [OP_PULSE_WIDTH-1:0] opPulses,
	input wire logic opBusy,
	input wire logic opDone,
	input wire logic opRefused,
	input wire logic memTick,
	input wire logic opEnable
);
	// ----
	// checks
	// ----
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// request taken at this edge, and a divider access
	wire logic busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic divAdr = wb_adr_i == MEMORY_CLOCK_DIVIDE_ADDR;
	a_ack_single: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
	a_flag_sets: assert property (busReq && wb_we_i && divAdr && wb_sel_i[0] |=> opEnable)
		else $error("loaded flag not set by write");
	a_flag_sticks: assert property (opEnable |=> opEnable) else $error("loaded flag lost");
	a_flag_reads: assert property (busReq && !wb_we_i && divAdr |=> wb_dat_o[LOADED_BIT] == opEnable)
		else $error("flag bit reads wrong");
	a_start_blocked: assert property (opStart && !opBusy && !opEnable |=> opRefused && !opBusy)
		else $error("operation not refused");
	a_start_runs: assert property (opStart && !opBusy && opEnable && opPulses != 0 |=> opBusy && !opRefused)
		else $error("operation not started");
	a_busy_loaded: assert property (opBusy |-> opEnable) else $error("busy while unloaded");
	a_tick_gated: assert property (!opEnable |-> !memTick) else $error("pulse before load");
	a_done_ends: assert property (opDone |-> $fell(opBusy)) else $error("done without busy end");
endmodule : memory_clock_divide_chk

bind memory_clock_divide_ctrl memory_clock_divide_chk #(.OP_PULSE_WIDTH(OP_PULSE_WIDTH)) chk_u (.*);

// File: flash_clock_divider_tb.sv
// Purpose: self-checking bench for the memory clock divider
// Assumes: default parameters, 100 MHz bus clock
// Notes: options, key and a refused operation first, then register rows, timing, operations and reset
`timescale 1ns/10ps
module flash_clock_divider_tb;
	import memory_clock_divide_pkg::*;
	// ----
	// signals
	// ----
	logic clk_sys = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, opStart = 0;
	logic [15:0] wb_adr_i = 16'h0, opPulses = 16'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, opBusy, opDone, opRefused, memTick, opEnable;
	logic [23:0] optionWork;
	logic [63:0] compareKey;
	int errors = 0, checked = 0, n;
	// rows: write, address, lanes, data, expected read
	typedef struct {logic w; logic [15:0] a; logic [3:0] s; logic [31:0] d, e;} memory_clock_divide_row_s;
	memory_clock_divide_row_s rows[8] = '{'{0, 16'h1820, 4'hF, 0, 0}, '{1, 16'h1820, 4'hE, 32'h45, 0},
		'{0, 16'h1820, 4'hF, 0, 0}, '{1, 16'h1820, 4'h1, 32'h83, 0}, '{0, 16'h1820, 4'hF, 0, 32'h83},
		'{1, 16'h1820, 4'hF, 32'h7F, 0}, '{0, 16'h1820, 4'hF, 0, 32'h83}, '{0, 16'h1900, 4'hF, 0, 0}};
	always #5 clk_sys = ~clk_sys;
	memory_clock_divide_ctrl dut_u (.*);
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
		k = 0;
		// look at ack mid-cycle, where it has settled, then release after the edge
		do begin
			@(negedge clk_sys);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (wb_ack_o !== 1'b1) errors++;
		rd = wb_dat_o;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	// bus cycles from one timing pulse to the next
	task automatic period;
		int k;
		k = 0;
		do @(negedge clk_sys); while (memTick !== 1'b1 && ++k < 2000);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (memTick !== 1'b1 && n < 2000);
	endtask : period
	// request an operation, count pulses while busy
	task automatic op(input logic [15:0] p, input logic refd);
		int t;
		@(posedge clk_sys);
		{opStart, opPulses} <= {1'b1, p};
		@(posedge clk_sys);
		opStart <= 1'b0;
		@(negedge clk_sys);
		chk("refused", opRefused, refd);
		chk("busy", opBusy, !refd);
		t = 0;
		n = 0;
		while (!refd && opDone !== 1'b1 && ++n < 5000) begin
			if (memTick === 1'b1 && opBusy === 1'b1) t++;
			@(negedge clk_sys);
		end
		if (!refd) chk("pulses", t, p);
	endtask : op
	// ----
	// sequence
	// ----
	initial begin
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		chk("options", {8'h00, optionWork}, 32'h0);
		chk("key low", compareKey[31:0], 32'h0);
		chk("key high", compareKey[63:32], 32'h0);
		chk("gate off", opEnable, 1'b0);
		op(16'h0002, 1);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
			if (!rows[i].w) chk("read", rd, rows[i].e);
		end
		chk("gate on", opEnable, 1'b1);
		period;
		chk("period", n, 4);
		op(16'h0003, 0);
		op(16'h0000, 1);
		// a second reset in mid-run clears the flag
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		wb(0, 16'h1820, 4'hF, 0);
		chk("reset read", rd, 32'h0);
		wb(1, 16'h1820, 4'h1, 32'h4C);
		wb(0, 16'h1820, 4'hF, 0);
		chk("prescaled read", rd, 32'hCC);
		period;
		chk("prescaled period", n, 104);
		give_verdict;
	end
	// watchdog against a hang
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
endmodule : flash_clock_divider_tb
